// ### verilog/gpic_pkg.sv
/*
 Constants for the game port input counters: register indices, field
 positions, reset values and timing counts.
 Assumes a 32-bit AXI4-Lite bus where byte address = 4 * register index.
*/
package gpic_pkg;

   // Register indices; byte address is four times the index
   localparam logic [29:0] GPIC_IDX_BEAM_HIGH   = 30'h0dff004;
   localparam logic [29:0] GPIC_IDX_BEAM_LOW    = 30'h0dff006;
   localparam logic [29:0] GPIC_IDX_MOTION1     = 30'h0dff00a;
   localparam logic [29:0] GPIC_IDX_MOTION2     = 30'h0dff00c;
   localparam logic [29:0] GPIC_IDX_POT1        = 30'h0dff012;
   localparam logic [29:0] GPIC_IDX_POT2        = 30'h0dff014;
   localparam logic [29:0] GPIC_IDX_POT_READ    = 30'h0dff016;
   localparam logic [29:0] GPIC_IDX_POT_START   = 30'h0dff034;
   localparam logic [29:0] GPIC_IDX_BPL_CTRL    = 30'h0dff100;
   localparam logic [29:0] GPIC_IDX_FIRE_PORT   = 30'h0bfe001;
   localparam logic [29:0] GPIC_IDX_BEAM_PIN    = 30'h0dff200;

   // Field positions
   localparam int unsigned GPIC_START_BIT  = 0;
   localparam int unsigned GPIC_LPEN_BIT   = 3;
   localparam int unsigned GPIC_FIRE1_BIT  = 6;
   localparam int unsigned GPIC_FIRE2_BIT  = 7;

   // Arbitrary identification values
   localparam logic [6:0]  GPIC_CHIP_REV   = 7'h15;
   localparam logic [13:0] GPIC_BEAM_ID    = 14'h0a5a;

   // Reset values
   localparam logic [7:0]  GPIC_POTCTL_RST = 8'h00;
   localparam logic [3:0]  GPIC_BPIN_RST   = 4'h0;
   localparam logic [13:0] GPIC_PIN_RST    = 14'h3fff;

   // Scan lines the pot capacitors are held discharged
   localparam logic [3:0]  GPIC_DUMP_LINES = 4'h8;

   // AXI responses
   localparam logic [1:0]  GPIC_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  GPIC_RESP_DEC   = 2'h3;

   typedef enum logic [1:0] {
      POT_IDLE,
      POT_DUMP,
      POT_COUNT
   } gpic_pot_state_e;

endpackage

// ### verilog/gpic_top.sv
/*
 Game port input counters for two controller ports: quadrature motion
 counters carrying joystick switches, pot measurement counters, fire
 buttons, pot and beam pin output control, light pen beam latch.
 Assumes pins are asynchronous, LINE_STROBE, VBLANK_END and the beam
 counters come from logic on CLK, and a single AXI4-Lite master.
*/
`timescale 1ns/1ns

module gpic_top
   import gpic_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic [31:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output wire logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output wire logic        S_AXI_WREADY,
   output logic      [1:0]  S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [31:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output wire logic        S_AXI_ARREADY,
   output logic      [31:0] S_AXI_RDATA,
   output logic      [1:0]  S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic [1:0]  VERTICAL_QUAD_A,
   input  wire logic [1:0]  HORIZONTAL_QUAD_A,
   input  wire logic [1:0]  VERTICAL_QUAD_B,
   input  wire logic [1:0]  HORIZONTAL_QUAD_B,
   input  wire logic [1:0]  FIRE_BEAM_I,
   output logic      [1:0]  FIRE_BEAM_O,
   output logic      [1:0]  FIRE_BEAM_OE,
   input  wire logic [3:0]  POT_PIN_I,
   output logic      [3:0]  POT_PIN_O,
   output logic      [3:0]  POT_PIN_OE,
   input  wire logic        LINE_STROBE,
   input  wire logic        VBLANK_END,
   input  wire logic [8:0]  BEAM_V,
   input  wire logic [8:0]  BEAM_H,
   input  wire logic        LONG_FRAME
);
   import gpic_pkg::*;

   function automatic logic is_idx(input logic [31:0] a,
                                   input logic [29:0] idx);
      is_idx = (a[31:2] == idx);
   endfunction

   // Closed switch reads one: pins are inverted before use
   function automatic logic [1:0] quad_state(input logic pin_b,
                                             input logic pin_a);
      quad_state = {~pin_b, pin_b ^ pin_a};
   endfunction

   function automatic logic [5:0] carry_step(input logic [1:0] o,
                                             input logic [1:0] n,
                                             input logic [5:0] up);
      if (o == 2'h3 && n == 2'h0) begin
         carry_step = up + 6'h01;
      end else if (o == 2'h0 && n == 2'h3) begin
         carry_step = up - 6'h01;
      end else begin
         carry_step = up;
      end
   endfunction

   // Pin synchronisers and a third stage for edge detection
   logic [13:0] pin_raw;
   logic [13:0] pin_s1_q;
   logic [13:0] pin_s2_q;
   logic [13:0] pin_q;

   assign pin_raw = {FIRE_BEAM_I, POT_PIN_I, HORIZONTAL_QUAD_B,
                     VERTICAL_QUAD_B, HORIZONTAL_QUAD_A, VERTICAL_QUAD_A};

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pin_s1_q <= GPIC_PIN_RST;
         pin_s2_q <= GPIC_PIN_RST;
         pin_q    <= GPIC_PIN_RST;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_q    <= pin_s2_q;
      end
   end

   wire [1:0] va_s = pin_s2_q[1:0];
   wire [1:0] ha_s = pin_s2_q[3:2];
   wire [1:0] vb_s = pin_s2_q[5:4];
   wire [1:0] hb_s = pin_s2_q[7:6];
   wire [3:0] pot_s = pin_s2_q[11:8];
   wire [1:0] fire_s = pin_s2_q[13:12];
   wire [1:0] va_q = pin_q[1:0];
   wire [1:0] ha_q = pin_q[3:2];
   wire [1:0] vb_q = pin_q[5:4];
   wire [1:0] hb_q = pin_q[7:6];
   wire [1:0] fire_q = pin_q[13:12];

   // Motion counters: low two bits follow the pins, so joystick switches
   // show directly; upper six bits move only on a Gray wrap, so a skipped
   // state adds nothing
   logic [5:0] h_up_q [2];
   logic [5:0] v_up_q [2];
   logic [15:0] motion [2];

   for (genvar p = 0; p < 2; p++) begin : g_port
      wire [1:0] h_old = quad_state(hb_q[p], ha_q[p]);
      wire [1:0] h_new = quad_state(hb_s[p], ha_s[p]);
      wire [1:0] v_old = quad_state(vb_q[p], va_q[p]);
      wire [1:0] v_new = quad_state(vb_s[p], va_s[p]);

      always_ff @(posedge CLK or posedge SYS_RST) begin
         if (SYS_RST) begin
            h_up_q[p] <= 6'h00;
            v_up_q[p] <= 6'h00;
         end else begin
            // Up on ascending Gray order, down on descending
            h_up_q[p] <= carry_step(h_old, h_new, h_up_q[p]);
            v_up_q[p] <= carry_step(v_old, v_new, v_up_q[p]);
         end
      end

      // Bit 9 left, bit 1 right vertical high byte
      assign motion[p] = {v_up_q[p], v_old, h_up_q[p], h_old};
   end

   // AXI4-Lite write channel: address and data held independently
   logic        aw_held_q;
   logic [31:0] awaddr_q;
   logic        w_held_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   assign S_AXI_AWREADY = ~aw_held_q & ~S_AXI_BVALID;
   assign S_AXI_WREADY  = ~w_held_q & ~S_AXI_BVALID;

   wire do_wr = aw_held_q & w_held_q & ~S_AXI_BVALID;
   wire wr_start  = do_wr & is_idx(awaddr_q, GPIC_IDX_POT_START);
   wire wr_bpl    = do_wr & is_idx(awaddr_q, GPIC_IDX_BPL_CTRL);
   wire wr_bpin   = do_wr & is_idx(awaddr_q, GPIC_IDX_BEAM_PIN);
   wire wr_mapped = wr_start | wr_bpl | wr_bpin
                  | is_idx(awaddr_q, GPIC_IDX_BEAM_HIGH)
                  | is_idx(awaddr_q, GPIC_IDX_BEAM_LOW)
                  | is_idx(awaddr_q, GPIC_IDX_MOTION1)
                  | is_idx(awaddr_q, GPIC_IDX_MOTION2)
                  | is_idx(awaddr_q, GPIC_IDX_POT1)
                  | is_idx(awaddr_q, GPIC_IDX_POT2)
                  | is_idx(awaddr_q, GPIC_IDX_POT_READ)
                  | is_idx(awaddr_q, GPIC_IDX_FIRE_PORT);
   wire go_pots = wr_start & wstrb_q[0] & wdata_q[GPIC_START_BIT];

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_held_q    <= 1'b0;
         awaddr_q     <= 32'h0;
         w_held_q     <= 1'b0;
         wdata_q      <= 32'h0;
         wstrb_q      <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= GPIC_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR;
         end else if (do_wr) begin
            aw_held_q <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
         end else if (do_wr) begin
            w_held_q <= 1'b0;
         end
         if (do_wr) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_mapped ? GPIC_RESP_OKAY : GPIC_RESP_DEC;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Software control registers
   logic [7:0] potctl_q;
   logic       lpen_en_q;
   logic [3:0] bpin_q;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         potctl_q  <= GPIC_POTCTL_RST;
         lpen_en_q <= 1'b0;
         bpin_q    <= GPIC_BPIN_RST;
      end else begin
         if (wr_start && wstrb_q[1]) begin
            potctl_q <= wdata_q[15:8];
         end
         if (wr_bpl && wstrb_q[0]) begin
            lpen_en_q <= wdata_q[GPIC_LPEN_BIT];
         end
         if (wr_bpin && wstrb_q[0]) begin
            bpin_q <= wdata_q[3:0];
         end
      end
   end

   // Pot measurement sequencer
   gpic_pot_state_e pot_st_q;
   logic [3:0]      line_q;
   logic [7:0]      pot_cnt_q [4];
   logic [3:0]      pot_done_q;

   wire dumping  = (pot_st_q == POT_DUMP);
   wire last_dump = LINE_STROBE && (line_q == GPIC_DUMP_LINES - 4'h1);

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pot_st_q   <= POT_IDLE;
         line_q     <= 4'h0;
         pot_done_q <= 4'hf;
      end else if (go_pots) begin
         pot_st_q   <= POT_DUMP;
         line_q     <= 4'h0;
         pot_done_q <= 4'h0;
      end else begin
         unique case (pot_st_q)
            POT_IDLE: begin
               line_q <= 4'h0;
            end
            POT_DUMP: begin
               if (LINE_STROBE) begin
                  line_q <= line_q + 4'h1;
               end
               if (last_dump) begin
                  pot_st_q <= POT_COUNT;
               end
            end
            POT_COUNT: begin
               if (LINE_STROBE) begin
                  pot_done_q <= pot_done_q | pot_s;
               end
               if (&pot_done_q) begin
                  pot_st_q <= POT_IDLE;
               end
            end
         endcase
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_pot
      always_ff @(posedge CLK or posedge SYS_RST) begin
         if (SYS_RST) begin
            pot_cnt_q[i] <= 8'h00;
         end else if (go_pots) begin
            pot_cnt_q[i] <= 8'h00;
         end else if (pot_st_q == POT_COUNT && LINE_STROBE
                      && !pot_done_q[i] && !pot_s[i]) begin
            // Pin low means charge still below threshold; wraps freely
            pot_cnt_q[i] <= pot_cnt_q[i] + 8'h01;
         end
      end
   end

   // Pin drivers: the dump forces pots low, overriding software output
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         POT_PIN_OE   <= 4'h0;
         POT_PIN_O    <= 4'h0;
         FIRE_BEAM_OE <= 2'h0;
         FIRE_BEAM_O  <= 2'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            POT_PIN_OE[i] <= dumping | potctl_q[2*i+1];
            POT_PIN_O[i]  <= ~dumping & potctl_q[2*i];
         end
         FIRE_BEAM_OE <= bpin_q[1:0];
         FIRE_BEAM_O  <= bpin_q[3:2];
      end
   end

   // Light pen: falling edge on either beam trigger freezes the beam
   // position until the end of vertical blank
   logic        frz_q;
   logic [8:0]  lat_v_q;
   logic [8:0]  lat_h_q;
   logic        lat_lof_q;

   wire trig = |(fire_q & ~fire_s);

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         frz_q     <= 1'b0;
         lat_v_q   <= 9'h000;
         lat_h_q   <= 9'h000;
         lat_lof_q <= 1'b0;
      end else if (lpen_en_q && trig && (!frz_q || VBLANK_END)) begin
         // A trigger in the release cycle wins: capture reopens there
         frz_q     <= 1'b1;
         lat_v_q   <= BEAM_V;
         lat_h_q   <= BEAM_H;
         lat_lof_q <= LONG_FRAME;
      end else if (VBLANK_END) begin
         frz_q <= 1'b0;
      end
   end

   wire [8:0] bv  = frz_q ? lat_v_q : BEAM_V;
   wire [8:0] bh  = frz_q ? lat_h_q : BEAM_H;
   wire       lof = frz_q ? lat_lof_q : LONG_FRAME;

   // Read decode
   logic [15:0] pot_rd;
   always_comb begin
      pot_rd = {8'h00, GPIC_CHIP_REV, 1'b0};
      for (int i = 0; i < 4; i++) begin
         pot_rd[9+2*i] = potctl_q[2*i+1];
         pot_rd[8+2*i] = pot_s[i];
      end
   end

   wire [31:0] ra = S_AXI_ARADDR;
   wire [7:0] fire_rd = {fire_s, 6'h00};

   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 32'h0;
      if (is_idx(ra, GPIC_IDX_MOTION1)) begin
         rd_word = {16'h0, motion[0]};
      end else if (is_idx(ra, GPIC_IDX_MOTION2)) begin
         rd_word = {16'h0, motion[1]};
      end else if (is_idx(ra, GPIC_IDX_POT1)) begin
         rd_word = {16'h0, pot_cnt_q[1], pot_cnt_q[0]};
      end else if (is_idx(ra, GPIC_IDX_POT2)) begin
         rd_word = {16'h0, pot_cnt_q[3], pot_cnt_q[2]};
      end else if (is_idx(ra, GPIC_IDX_POT_READ)) begin
         rd_word = {16'h0, pot_rd};
      end else if (is_idx(ra, GPIC_IDX_FIRE_PORT)) begin
         rd_word = {24'h0, fire_rd};
      end else if (is_idx(ra, GPIC_IDX_BEAM_HIGH)) begin
         rd_word = {16'h0, lof, GPIC_BEAM_ID, bv[8]};
      end else if (is_idx(ra, GPIC_IDX_BEAM_LOW)) begin
         rd_word = {16'h0, bv[7:0], bh[8:1]};
      end else if (is_idx(ra, GPIC_IDX_BEAM_PIN)) begin
         rd_word = {28'h0, bpin_q};
      end else if (is_idx(ra, GPIC_IDX_POT_START)
                   || is_idx(ra, GPIC_IDX_BPL_CTRL)) begin
         rd_word = 32'h0;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read channel: one outstanding read, data one edge after address
   assign S_AXI_ARREADY = ~S_AXI_RVALID;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0;
         S_AXI_RRESP  <= GPIC_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA  <= rd_word;
         S_AXI_RRESP  <= rd_hit ? GPIC_RESP_OKAY : GPIC_RESP_DEC;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

endmodule

// ### bench/gpic_properties.sv
/*
 Concurrent checks on the game port block: bus answer timing and the pot
 dump and release sequence seen at the pot pins.
 Assumes it is bound to gpic_top and that every pot start write is a full
 word with the pot pin output bits clear.
*/
`timescale 1ns/1ns
module gpic_properties
   import gpic_pkg::*;
(
   input wire logic        CLK,
   input wire logic        SYS_RST,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0]  S_AXI_WSTRB,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic        LINE_STROBE,
   input wire logic [3:0]  POT_PIN_O,
   input wire logic [3:0]  POT_PIN_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   wire  [29:0] ar_idx = S_AXI_ARADDR[31:2];
   wire         ar_map = ar_idx inside {GPIC_IDX_BEAM_HIGH, GPIC_IDX_BEAM_LOW,
      GPIC_IDX_MOTION1, GPIC_IDX_MOTION2, GPIC_IDX_POT1, GPIC_IDX_POT2,
      GPIC_IDX_POT_READ, GPIC_IDX_POT_START, GPIC_IDX_BPL_CTRL,
      GPIC_IDX_FIRE_PORT, GPIC_IDX_BEAM_PIN};
   logic        aw_st_q;
   logic        w_st_q;
   logic        armed_q;
   logic [3:0]  lines_q;

   // Line count since the last start write, saturating past the dump
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_st_q <= 1'b0;
         w_st_q  <= 1'b0;
         armed_q <= 1'b0;
         lines_q <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
            aw_st_q <= S_AXI_AWADDR[31:2] == GPIC_IDX_POT_START;
         if (S_AXI_WVALID && S_AXI_WREADY)
            w_st_q <= S_AXI_WDATA[0] && S_AXI_WSTRB[0];
         if ($rose(S_AXI_BVALID) && aw_st_q && w_st_q) begin
            armed_q <= 1'b1;
            lines_q <= {3'h0, LINE_STROBE};
         end else if (LINE_STROBE && lines_q < 4'ha)
            lines_q <= lines_q + 4'h1;
      end
   end

   AST_WR_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY
      && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID)
      else $error("write answer late");
   AST_WR_STANDS: assert property (S_AXI_BVALID && !S_AXI_BREADY
      |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write answer dropped");
   AST_WR_REFUSE: assert property (S_AXI_BVALID
      |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while answering");
   AST_RD_ANSWER: assert property (S_AXI_ARVALID && !S_AXI_RVALID
      |=> S_AXI_RVALID)
      else $error("read answer late");
   AST_RD_STANDS: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data unstable");
   AST_RD_REFUSE: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while answering");
   AST_RD_UNMAP: assert property (S_AXI_ARVALID && !S_AXI_RVALID
      && !ar_map |=> S_AXI_RRESP == GPIC_RESP_DEC && S_AXI_RDATA == 32'h0)
      else $error("unmapped read answered");
   AST_DUMP_HOLD: assert property (armed_q && lines_q < 4'h8
      |-> POT_PIN_OE == 4'hf && POT_PIN_O == 4'h0)
      else $error("pot capacitors not held discharged");
   AST_DUMP_END: assert property (armed_q && lines_q == 4'ha
      |-> POT_PIN_OE == 4'h0)
      else $error("pot pins not released to charge");

   cover property (armed_q && lines_q == 4'ha);
   cover property (S_AXI_RVALID && S_AXI_RRESP == GPIC_RESP_DEC);
   cover property (S_AXI_BVALID && S_AXI_BRESP == GPIC_RESP_DEC);
endmodule

// ### bench/gpic_pad_model.sv
/*
 Controllers on both game ports: mouse wheels, joystick switches, fire
 buttons and pot capacitors.
 Assumes the bench calls its tasks and that pins not driven by the block
 are pulled up, so an open switch reads high.
*/
`timescale 1ns/1ns
module gpic_pad_model (
   input  wire logic       clk,
   input  wire logic       line_strobe,
   input  wire logic [3:0] pot_oe,
   input  wire logic [3:0] pot_o,
   input  wire logic [1:0] fire_oe,
   input  wire logic [1:0] fire_o,
   output logic      [1:0] vqa,
   output logic      [1:0] hqa,
   output logic      [1:0] vqb,
   output logic      [1:0] hqb,
   output logic      [1:0] fire_i,
   output logic      [3:0] pot_i
);
   logic [1:0] hs [2] = '{2'h0, 2'h0};
   logic [1:0] vs [2] = '{2'h0, 2'h0};
   logic [1:0] fire_n = 2'h3;
   int         lim [4] = '{default: 0};
   int         cnt [4] = '{default: 0};

   // Wheel state to two trains a quarter cycle apart, low when closed
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         hqb[p] = ~hs[p][1];
         hqa[p] = ~(hs[p][1] ^ hs[p][0]);
         vqb[p] = ~vs[p][1];
         vqa[p] = ~(vs[p][1] ^ vs[p][0]);
         fire_i[p] = fire_oe[p] ? fire_o[p] : fire_n[p];
      end
      for (int i = 0; i < 4; i++)
         pot_i[i] = pot_oe[i] ? pot_o[i] : (cnt[i] >= lim[i]);
   end

   // Capacitor charges only while the block leaves the pin alone
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++)
         if (pot_oe[i])
            cnt[i] <= 0;
         else if (line_strobe)
            cnt[i] <= cnt[i] + 1;
   end

   task automatic move(input int p, input logic ax, input int n);
      logic [1:0] st;
      st = n < 0 ? 2'h3 : 2'h1;
      repeat (n < 0 ? -n : n) begin
         @(posedge clk);
         if (ax)
            vs[p] <= vs[p] + st;
         else
            hs[p] <= hs[p] + st;
         repeat (3) @(posedge clk);
      end
   endtask

   task automatic put(input int p, input logic [1:0] h, input logic [1:0] v);
      @(posedge clk);
      hs[p] <= h;
      vs[p] <= v;
      repeat (4) @(posedge clk);
   endtask

   task automatic press(input logic [1:0] n);
      @(posedge clk);
      fire_n <= n;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ### bench/tb_top.sv
/*
 Self-checking bench for the game port block: register map, motion
 counts, switches, buttons, pin outputs, pot measurement and light pen.
 Assumes the controller model and the bound property checker.
*/
`timescale 1ns/1ns
module tb_top;
   import gpic_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, d, e;
   logic [3:0]  wstrb = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, line = 0, vbl = 0;
   logic [8:0]  beam_h = '0;
   logic [1:0]  r;
   logic [7:0]  prev;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp, vqa, hqa, vqb, hqb, fire_i, fire_o, fire_oe;
   wire  [31:0] rdata;
   wire  [3:0]  pot_i, pot_o, pot_oe;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;

   gpic_top DUT (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .VERTICAL_QUAD_A(vqa),
      .HORIZONTAL_QUAD_A(hqa), .VERTICAL_QUAD_B(vqb),
      .HORIZONTAL_QUAD_B(hqb), .FIRE_BEAM_I(fire_i), .FIRE_BEAM_O(fire_o),
      .FIRE_BEAM_OE(fire_oe), .POT_PIN_I(pot_i), .POT_PIN_O(pot_o),
      .POT_PIN_OE(pot_oe), .LINE_STROBE(line), .VBLANK_END(vbl),
      .BEAM_V(9'h0a), .BEAM_H(beam_h), .LONG_FRAME(1'b0));

   gpic_pad_model pad (.clk(clk), .line_strobe(line), .pot_oe(pot_oe),
      .pot_o(pot_o), .fire_oe(fire_oe), .fire_o(fire_o), .vqa(vqa),
      .hqa(hqa), .vqb(vqb), .hqb(hqb), .fire_i(fire_i), .pot_i(pot_i));

   initial forever #20 clk = ~clk;
   always @(posedge clk) beam_h <= beam_h + 9'h1;
   // Whole run needs about 1800 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic wr(input logic [29:0] i, input logic [31:0] v,
                     input logic [3:0] s);
      @(posedge clk);
      awaddr <= {i, 2'h0};
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [29:0] i);
      @(posedge clk);
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic strobes(input int n);
      repeat (n) begin
         repeat (7) @(posedge clk);
         line <= 1'b1;
         @(posedge clk);
         line <= 1'b0;
      end
   endtask

   task automatic t_regs();
      rd(GPIC_IDX_MOTION2);
      chk("motion2 reset", d, 32'h0);
      rd(GPIC_IDX_POT2);
      chk("pot2 reset", d, 32'h0);
      rd(30'h0);
      chk("unmapped read", {d[29:0], r}, {30'h0, GPIC_RESP_DEC});
      wr(30'h0, 32'h1, 4'hf);
      chk("unmapped write", r, GPIC_RESP_DEC);
      wr(GPIC_IDX_MOTION1, 32'h1234, 4'hf);
      rd(GPIC_IDX_MOTION1);
      chk("read only write", {d[29:0], r}, 32'h0);
   endtask

   task automatic t_motion();
      pad.move(0, 1'b0, 5);
      pad.move(1, 1'b1, -7);
      rd(GPIC_IDX_MOTION1);
      chk("motion1 right", d, 32'h0005);
      prev = d[7:0];
      rd(GPIC_IDX_MOTION2);
      chk("motion2 up", d, 32'hf900);
      pad.move(0, 1'b0, -10);
      pad.move(0, 1'b1, 300);
      rd(GPIC_IDX_MOTION1);
      chk("left speed", 8'(d[7:0] - prev), 8'hf6);
      chk("motion1 wrap", d, 32'h2cfb);
      pad.put(0, 2'h1, 2'h0);
      rd(GPIC_IDX_MOTION1);
      chk("skipped step", d, 32'h2cf9);
   endtask

   task automatic t_switches();
      for (int k = 0; k < 16; k++) begin
         pad.put(1, {k[0], k[0] ^ k[1]}, {k[2], k[2] ^ k[3]});
         rd(GPIC_IDX_MOTION2);
         chk("rl", {d[9], d[1]}, {k[2], k[0]});
         chk("fb", {d[9]^d[8], d[1]^d[0]}, {k[3], k[1]});
      end
      for (int k = 0; k < 4; k++) begin
         pad.press(k[1:0]);
         rd(GPIC_IDX_FIRE_PORT);
         chk("fire buttons", d[7:6], k[1:0]);
      end
   endtask

   task automatic t_pins();
      wr(GPIC_IDX_POT_START, 32'hb400, 4'h2);
      // Driven levels need two edges through the pin synchroniser
      repeat (2) @(posedge clk);
      rd(GPIC_IDX_POT_READ);
      chk("pot pin drive", {pot_oe, pot_o[3:2]}, 6'h31);
      chk("pot pin read", d[15:12], 4'hb);
      wr(GPIC_IDX_BEAM_PIN, 32'h1, 4'h1);
      repeat (2) @(posedge clk);
      rd(GPIC_IDX_FIRE_PORT);
      chk("beam pin drive", {fire_oe, fire_o[0], d[7:6]}, 5'h0a);
      wr(GPIC_IDX_BEAM_PIN, 32'h0, 4'h1);
      wr(GPIC_IDX_POT_START, 32'h0, 4'h2);
   endtask

   task automatic t_pot();
      pad.lim = '{0, 3, 5, 12};
      wr(GPIC_IDX_POT_START, 32'h1, 4'hf);
      strobes(8);
      rd(GPIC_IDX_POT1);
      chk("pot in dump", d, 32'h0);
      strobes(17);
      rd(GPIC_IDX_POT1);
      chk("pot1 counts", d, 32'h0300);
      strobes(4);
      rd(GPIC_IDX_POT2);
      chk("pot2 held", d, 32'h0c05);
      wr(GPIC_IDX_POT_START, 32'h0, 4'hf);
      wr(GPIC_IDX_POT_START, 32'h1, 4'he);
      rd(GPIC_IDX_POT2);
      chk("pot no clear", d, 32'h0c05);
      wr(GPIC_IDX_POT_START, 32'h1, 4'hf);
      rd(GPIC_IDX_POT2);
      chk("pot cleared", d, 32'h0);
   endtask

   task automatic t_pen();
      for (int k = 0; k < 2; k++) begin
         wr(GPIC_IDX_BPL_CTRL, k ? 32'h8 : 32'h0, 4'h1);
         pad.press(2'h1);
         rd(GPIC_IDX_BEAM_LOW);
         e = d;
         rd(GPIC_IDX_BEAM_LOW);
         chk("pen latch", d == e, k[0]);
         pad.press(2'h3);
      end
      @(posedge clk);
      vbl <= 1'b1;
      @(posedge clk);
      vbl <= 1'b0;
      rd(GPIC_IDX_BEAM_LOW);
      e = d;
      rd(GPIC_IDX_BEAM_LOW);
      chk("pen released", d == e, 1'b0);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_motion();
      t_switches();
      t_pins();
      t_pot();
      t_pen();
      give_verdict();
   end
endmodule

bind gpic_top gpic_properties chk (.CLK(CLK), .SYS_RST(SYS_RST),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .LINE_STROBE(LINE_STROBE),
   .POT_PIN_O(POT_PIN_O), .POT_PIN_OE(POT_PIN_OE));
